// File: inc/qhp_pkg.sv
package qhp_pkg;

  // Port kind codes, formed as {port_kind_sel_hi, port_kind_sel_lo}.
  localparam logic [1:0] PORT_MUX    = 2'h0;
  localparam logic [1:0] PORT_NONMUX = 2'h1;
  localparam logic [1:0] PORT_SERIAL = 2'h2;
  localparam logic [1:0] PORT_TEST   = 2'h3;

  // Strobe conventions picked by timing_style_sel.
  localparam logic STYLE_SPLIT  = 1'h0;
  localparam logic STYLE_STROBE = 1'h1;

  // Serial command byte layout, least significant bit sent first.
  localparam int CMD_READ_BIT  = 0;
  localparam int CMD_ADDR_LSB  = 1;
  localparam int CMD_ADDR_MSB  = 5;
  localparam int CMD_BURST_BIT = 7;

  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [2:0] BIT_RESET      = 3'h0;
  localparam logic [5:0] ADDR_RESET     = 6'h00;
  localparam logic [4:0] SER_ADDR_RESET = 5'h00;
  localparam logic [7:0] BYTE_RESET     = 8'h00;
  localparam logic [1:0] UNIT_RESET     = 2'h0;
  localparam logic       PIN_IDLE_LEVEL = 1'h1;
  localparam logic [7:0] OE_ALL         = 8'hff;
  localparam logic [7:0] OE_SER_OUT     = 8'h80;
  localparam logic [7:0] OE_NONE        = 8'h00;

  typedef enum logic [4:0] {
    SER_IDLE  = 5'h01,
    SER_CMD   = 5'h02,
    SER_WDATA = 5'h04,
    SER_RDATA = 5'h08,
    SER_DONE  = 5'h10
  } qhp_ser_state_type;

endpackage : qhp_pkg

// File: rtl/qhp_pin_track.sv
`timescale 1ns/10ps
module qhp_pin_track #(
  parameter logic RESET_LEVEL = 1'h1
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Pin level and its history
  input  wire logic level,
  output logic      prev,
  output logic      rise,
  output logic      fall
);

  logic next_prev;

  always_comb begin
    next_prev = level;
    rise      = level & ~prev;
    fall      = ~level & prev;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev <= RESET_LEVEL;
    end else begin
      prev <= next_prev;
    end
  end

endmodule : qhp_pin_track

// File: rtl/qhp_host_port.sv
`timescale 1ns/10ps
// Behaviour
// - Chip select low required; else strobes ignored
// - Unit select pins pick target register set
// - Port kind pins: mux, nonmux, serial, test
// - Timing style: split strobes or data strobe
// - Shared lines carry data, or address then data
// - Latch pin: upper address bit or latch
// - Read strobe low; data strobe high when muxed
// - Write or direction low means write
// - Pending enabled status pulls interrupt low outside test mode
// - Serial output changes on selected clock edge
// - Serial input sampled on selected clock edge
// - Serial mode repurposes address, data, strobe pins
// - Port kind encoding of the two selects
// - Edge select low/high gives rising/falling sample edge, falling/rising output edge
// - Chip select high aborts serial, output released
module qhp_host_port #(
  parameter int INT_SOURCES = 4
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  // Mode straps
  input  wire logic                   portKindSelLo,
  input  wire logic                   portKindSelHi,
  input  wire logic                   timingStyleSel,
  // Host bus pins
  input  wire logic                   csN,
  input  wire logic                   unitSelectLo,
  input  wire logic                   unitSelectHi,
  input  wire logic [4:0]             lowAddrLines,
  input  wire logic                   addrStrobe,
  input  wire logic                   strobePin,
  input  wire logic                   dirPin,
  input  wire logic [7:0]             addrDataIn,
  output logic      [7:0]             addrDataOut,
  output logic      [7:0]             addrDataOe,
  // Interrupt pin, open drain
  input  wire logic [INT_SOURCES-1:0] intPending,
  output logic                        intOut,
  output logic                        intOe,
  // Register set side
  output logic                        regRead,
  output logic                        regWrite,
  output logic      [1:0]             regUnit,
  output logic      [5:0]             regAddr,
  output logic      [7:0]             regWdata,
  input  wire logic [7:0]             regRdata
);

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  logic                      csPrevN, aleRise, strobePrev, strobeRise, strobeFall, dirPrev;
  logic                      isMux, isNonMux, isSerial, isTest, isParallel, moto;
  logic                      rdAct, rdActPrev, wrAct, wrActPrev, parReadStart, parWriteEnd;
  logic                      sampleEdge, outEdge, curOutBit;
  logic [1:0]                kind, unitPins;
  logic [5:0]                parAddr, pinAddr, adLow;
  logic [7:0]                newByte;
  qhp_pkg::qhp_ser_state_type serState, next_serState;
  logic [2:0]                bitCnt, next_bitCnt, outCnt, next_outCnt;
  logic [4:0]                serAddr, next_serAddr;
  logic [5:0]                muxAddr, next_muxAddr, next_regAddr;
  logic [7:0]                shiftIn, next_shiftIn, rdByte, next_rdByte, wdataHold, next_wdataHold;
  logic [7:0]                next_regWdata, next_addrDataOut, next_addrDataOe;
  logic [1:0]                next_regUnit;
  logic                      serBurst, next_serBurst, loadPend, next_loadPend, sdoBit, next_sdoBit;
  logic                      next_regRead, next_regWrite, next_intOe;

  qhp_pin_track #(.RESET_LEVEL(qhp_pkg::PIN_IDLE_LEVEL)) csTrack (
    .sys_clk(sys_clk), .reset_n(reset_n), .level(csN), .prev(csPrevN), .rise(), .fall());
  qhp_pin_track #(.RESET_LEVEL(qhp_pkg::PIN_IDLE_LEVEL)) aleTrack (
    .sys_clk(sys_clk), .reset_n(reset_n), .level(addrStrobe), .prev(), .rise(aleRise), .fall());
  qhp_pin_track #(.RESET_LEVEL(qhp_pkg::PIN_IDLE_LEVEL)) strobeTrack (
    .sys_clk(sys_clk), .reset_n(reset_n), .level(strobePin), .prev(strobePrev), .rise(strobeRise),
    .fall(strobeFall));
  qhp_pin_track #(.RESET_LEVEL(qhp_pkg::PIN_IDLE_LEVEL)) dirTrack (
    .sys_clk(sys_clk), .reset_n(reset_n), .level(dirPin), .prev(dirPrev), .rise(), .fall());

  // Polarity of both strobe conventions; the data strobe flips when the bus is multiplexed.
  function automatic logic busActive(input logic strobeLvl, input logic dirLvl, input logic wantRead,
                                     input logic dsStyle, input logic muxed);
    logic strobeOn;
    strobeOn = muxed ? strobeLvl : ~strobeLvl;
    if (dsStyle) begin
      busActive = strobeOn & (wantRead ? dirLvl : ~dirLvl);
    end else begin
      busActive = wantRead ? ~strobeLvl : ~dirLvl;
    end
  endfunction : busActive

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    kind         = {portKindSelHi, portKindSelLo};
    isMux        = (kind == qhp_pkg::PORT_MUX);
    isNonMux     = (kind == qhp_pkg::PORT_NONMUX);
    isSerial     = (kind == qhp_pkg::PORT_SERIAL);
    isTest       = (kind == qhp_pkg::PORT_TEST);
    isParallel   = isMux | isNonMux;
    moto         = (timingStyleSel == qhp_pkg::STYLE_STROBE);
    unitPins     = {unitSelectHi, unitSelectLo};
    pinAddr      = {addrStrobe, lowAddrLines};
    adLow        = addrDataIn[5:0];
    rdAct        = busActive(strobePin, dirPin, 1'b1, moto, isMux);
    rdActPrev    = busActive(strobePrev, dirPrev, 1'b1, moto, isMux);
    wrAct        = busActive(strobePin, dirPin, 1'b0, moto, isMux);
    wrActPrev    = busActive(strobePrev, dirPrev, 1'b0, moto, isMux);
    parReadStart = isParallel & ~csN & rdAct & ~rdActPrev;
    // Writes commit at the end of the strobe; the select of the cycle before still counts.
    parWriteEnd  = isParallel & ~csPrevN & wrActPrev & ~wrAct;
    parAddr      = isMux ? muxAddr : pinAddr;
    // Serial reuse of pins: strobe is the clock, direction is the input, address bits pick edges.
    sampleEdge   = lowAddrLines[0] ? strobeFall : strobeRise;
    outEdge      = lowAddrLines[1] ? strobeRise : strobeFall;
    newByte      = {dirPin, shiftIn[7:1]};
    curOutBit    = rdByte[outCnt];
  end

  always_comb begin
    next_muxAddr   = (isMux && aleRise) ? adLow : muxAddr;
    next_wdataHold = wrAct ? addrDataIn : wdataHold;
    next_regRead   = 1'b0;
    next_regWrite  = 1'b0;
    next_regAddr   = regAddr;
    next_regUnit   = regUnit;
    next_regWdata  = regWdata;
    next_serState  = serState;
    next_bitCnt    = bitCnt;
    next_outCnt    = outCnt;
    next_shiftIn   = shiftIn;
    next_serAddr   = serAddr;
    next_serBurst  = serBurst;
    next_rdByte    = rdByte;
    next_loadPend  = 1'b0;
    next_sdoBit    = sdoBit;
    if (parReadStart) begin
      next_regRead = 1'b1;
      next_regAddr = parAddr;
      next_regUnit = unitPins;
    end else if (parWriteEnd) begin
      next_regWrite = 1'b1;
      next_regAddr  = parAddr;
      next_regUnit  = unitPins;
      next_regWdata = wdataHold;
    end
    if (!isSerial || csN) begin
      next_serState = qhp_pkg::SER_IDLE;
      next_bitCnt   = qhp_pkg::BIT_RESET;
      next_outCnt   = qhp_pkg::BIT_RESET;
    end else begin
      case (serState)
        qhp_pkg::SER_IDLE: begin
          next_serState = qhp_pkg::SER_CMD;
        end
        qhp_pkg::SER_CMD: begin
          if (sampleEdge) begin
            next_bitCnt  = bitCnt + 3'h1;
            next_shiftIn = newByte;
            if (bitCnt == qhp_pkg::BIT_LAST) begin
              // The reserved bit of the command is not checked.
              next_serAddr  = newByte[qhp_pkg::CMD_ADDR_MSB:qhp_pkg::CMD_ADDR_LSB];
              next_serBurst = newByte[qhp_pkg::CMD_BURST_BIT];
              if (newByte[qhp_pkg::CMD_READ_BIT]) begin
                next_serState = qhp_pkg::SER_RDATA;
                next_regRead  = 1'b1;
                next_regAddr  = {1'b0, newByte[qhp_pkg::CMD_ADDR_MSB:qhp_pkg::CMD_ADDR_LSB]};
                next_regUnit  = unitPins;
                next_loadPend = 1'b1;
                next_outCnt   = qhp_pkg::BIT_RESET;
              end else begin
                next_serState = qhp_pkg::SER_WDATA;
              end
            end
          end
        end
        qhp_pkg::SER_WDATA: begin
          if (sampleEdge) begin
            next_bitCnt  = bitCnt + 3'h1;
            next_shiftIn = newByte;
            if (bitCnt == qhp_pkg::BIT_LAST) begin
              next_regWrite = 1'b1;
              next_regAddr  = {1'b0, serAddr};
              next_regUnit  = unitPins;
              next_regWdata = newByte;
              next_serAddr  = serAddr + 5'h01;
              if (!serBurst) begin
                next_serState = qhp_pkg::SER_DONE;
              end
            end
          end
        end
        qhp_pkg::SER_RDATA: begin
          // Read data is taken the cycle after the request, so an output edge then would be lost.
          if (loadPend) begin
            next_rdByte = regRdata;
          end else if (outEdge) begin
            next_sdoBit = curOutBit;
            next_outCnt = outCnt + 3'h1;
            if (outCnt == qhp_pkg::BIT_LAST) begin
              if (serBurst) begin
                next_serAddr  = serAddr + 5'h01;
                next_regRead  = 1'b1;
                next_regAddr  = {1'b0, 5'(serAddr + 5'h01)};
                next_regUnit  = unitPins;
                next_loadPend = 1'b1;
              end else begin
                next_serState = qhp_pkg::SER_DONE;
              end
            end
          end
        end
        qhp_pkg::SER_DONE: begin
          next_serState = qhp_pkg::SER_DONE;
        end
        default: begin
          next_serState = qhp_pkg::SER_IDLE;
        end
      endcase
    end
    if (isParallel && !csN && rdAct) begin
      next_addrDataOe = qhp_pkg::OE_ALL;
    end else if (isSerial && (next_serState == qhp_pkg::SER_RDATA ||
                 (next_serState == qhp_pkg::SER_DONE && addrDataOe[7]))) begin
      next_addrDataOe = qhp_pkg::OE_SER_OUT;
    end else begin
      next_addrDataOe = qhp_pkg::OE_NONE;
    end
    next_addrDataOut = isSerial ? {next_sdoBit, 7'h00} : regRdata;
    next_intOe       = (|intPending) & ~isTest;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      muxAddr     <= qhp_pkg::ADDR_RESET;
      wdataHold   <= qhp_pkg::BYTE_RESET;
      regRead     <= 1'b0;
      regWrite    <= 1'b0;
      regAddr     <= qhp_pkg::ADDR_RESET;
      regUnit     <= qhp_pkg::UNIT_RESET;
      regWdata    <= qhp_pkg::BYTE_RESET;
      serState    <= qhp_pkg::SER_IDLE;
      bitCnt      <= qhp_pkg::BIT_RESET;
      outCnt      <= qhp_pkg::BIT_RESET;
      shiftIn     <= qhp_pkg::BYTE_RESET;
      serAddr     <= qhp_pkg::SER_ADDR_RESET;
      serBurst    <= 1'b0;
      rdByte      <= qhp_pkg::BYTE_RESET;
      loadPend    <= 1'b0;
      sdoBit      <= 1'b0;
      addrDataOut <= qhp_pkg::BYTE_RESET;
      addrDataOe  <= qhp_pkg::OE_NONE;
      intOut      <= 1'b0;
      intOe       <= 1'b0;
    end else begin
      muxAddr     <= next_muxAddr;
      wdataHold   <= next_wdataHold;
      regRead     <= next_regRead;
      regWrite    <= next_regWrite;
      regAddr     <= next_regAddr;
      regUnit     <= next_regUnit;
      regWdata    <= next_regWdata;
      serState    <= next_serState;
      bitCnt      <= next_bitCnt;
      outCnt      <= next_outCnt;
      shiftIn     <= next_shiftIn;
      serAddr     <= next_serAddr;
      serBurst    <= next_serBurst;
      rdByte      <= next_rdByte;
      loadPend    <= next_loadPend;
      sdoBit      <= next_sdoBit;
      addrDataOut <= next_addrDataOut;
      addrDataOe  <= next_addrDataOe;
      intOut      <= 1'b0;
      intOe       <= next_intOe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_split_read_go;
    isParallel && !moto && !csN && !strobePin && strobePrev;
  endsequence

  sequence s_ser_sample;
    isSerial && !csN && (serState == qhp_pkg::SER_CMD || serState == qhp_pkg::SER_WDATA) &&
      (lowAddrLines[0] ? (!strobePin && strobePrev) : (strobePin && !strobePrev));
  endsequence

  a_cs_high_quiet: assert property (csN [*2] |=> !regRead && !regWrite)
    else $error("register access issued while chip select high");
  a_unit_sel_kept: assert property (regRead |-> regUnit == $past(unitPins))
    else $error("register read aimed at wrong unit");
  a_test_mode_hiz: assert property (isTest |=> addrDataOe == qhp_pkg::OE_NONE && !intOe)
    else $error("output driven in test mode");
  a_split_read_go: assert property (s_split_read_go |=> regRead)
    else $error("split strobe read not started");
  a_mux_ds_high: assert property (isMux && moto && !csN && dirPin && strobePin && !strobePrev |=> regRead)
    else $error("muxed data strobe read not started");
  a_write_low_end: assert property (isParallel && !moto && !csPrevN && dirPin && !dirPrev
                                    |=> regWrite && regWdata == $past(wdataHold))
    else $error("write strobe end did not commit data");
  a_nonmux_addr: assert property (parReadStart && isNonMux |=> regAddr == $past(pinAddr))
    else $error("nonmultiplexed address not taken from pins");
  a_mux_addr_latch: assert property (isMux && addrStrobe && !$past(addrStrobe) |=> muxAddr == $past(adLow))
    else $error("multiplexed address not latched on rising latch");
  a_int_follow: assert property (|intPending && !isTest |=> intOe)
    else $error("interrupt not asserted for pending status");
  a_ser_sample_edge: assert property (s_ser_sample |=> bitCnt == 3'($past(bitCnt) + 3'h1))
    else $error("serial input not sampled on chosen edge");
  a_ser_out_edge: assert property (isSerial && !csN && serState == qhp_pkg::SER_RDATA && !loadPend &&
                                   (lowAddrLines[1] ? (strobePin && !strobePrev) : (!strobePin && strobePrev))
                                   |=> addrDataOut[7] == $past(curOutBit))
    else $error("serial output not updated on chosen edge");
  a_ser_abort: assert property (csN |=> serState == qhp_pkg::SER_IDLE && addrDataOe == qhp_pkg::OE_NONE)
    else $error("serial transfer not aborted by chip select");

endmodule : qhp_host_port

// File: bench/qhp_reg_model.sv
`timescale 1ns/10ps
module qhp_reg_model (
  // Clock
  input  wire logic       sys_clk,
  // Register set side
  input  wire logic       regWrite,
  input  wire logic [1:0] regUnit,
  input  wire logic [5:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata
);
  logic [7:0] mem [0:255];

  // Reads are combinational, so data is ready well before the port samples it.
  always @(posedge sys_clk) begin
    if (regWrite === 1'b1) mem[{regUnit, regAddr}] <= regWdata;
  end

  assign regRdata = mem[{regUnit, regAddr}];
endmodule : qhp_reg_model

// File: bench/tb.sv
`timescale 1ns/10ps
module tb;
  logic       sys_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       portKindSelLo, portKindSelHi, timingStyleSel, csN;
  logic       unitSelectLo, unitSelectHi, addrStrobe, strobePin, dirPin;
  logic [4:0] lowAddrLines;
  logic [7:0] hostBus, addrDataIn, addrDataOut, addrDataOe, regWdata, regRdata, r;
  logic [3:0] intPending;
  logic       intOut, intOe, regRead, regWrite;
  logic [1:0] regUnit;
  logic [5:0] regAddr;
  int         errors = 0;
  int         samplesChecked = 0;
  int         nRd = 0;
  int         nWr = 0;

  always #4 sys_clk = ~sys_clk;

  // The shared lines carry the device's value on every bit it enables.
  assign addrDataIn = (addrDataOe & addrDataOut) | (~addrDataOe & hostBus);

  always @(posedge sys_clk) begin
    nRd += (regRead === 1'b1);
    nWr += (regWrite === 1'b1);
  end

  qhp_host_port #(.INT_SOURCES(4)) dut_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .portKindSelLo(portKindSelLo),
    .portKindSelHi(portKindSelHi), .timingStyleSel(timingStyleSel), .csN(csN),
    .unitSelectLo(unitSelectLo), .unitSelectHi(unitSelectHi), .lowAddrLines(lowAddrLines),
    .addrStrobe(addrStrobe), .strobePin(strobePin), .dirPin(dirPin), .addrDataIn(addrDataIn),
    .addrDataOut(addrDataOut), .addrDataOe(addrDataOe), .intPending(intPending),
    .intOut(intOut), .intOe(intOe), .regRead(regRead), .regWrite(regWrite),
    .regUnit(regUnit), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));

  qhp_reg_model model_u (.sys_clk(sys_clk), .regWrite(regWrite), .regUnit(regUnit),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));

  ////////////////////////////////////////////////////////////////////////////
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  task chk(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task final_report;
    $display("errors=%0d samplesChecked=%0d", errors, samplesChecked);
    if (errors == 0 && samplesChecked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  task set_mode(input logic [1:0] k, input logic st);
    csN <= 1'b1;
    {portKindSelHi, portKindSelLo} <= k;
    timingStyleSel <= st;
    strobePin <= !(st && k == qhp_pkg::PORT_MUX);
    dirPin <= 1'b1;
    addrStrobe <= 1'b0;
    tick(4);
  endtask : set_mode

  // One parallel access; the active strobe level follows the current mode.
  task automatic par(input bit rd, input logic [1:0] u, input logic [5:0] a, input logic [7:0] d);
    logic mux;
    logic act;
    int   r0;
    int   w0;
    mux = ({portKindSelHi, portKindSelLo} == qhp_pkg::PORT_MUX);
    act = mux && timingStyleSel;
    r0 = nRd;
    w0 = nWr;
    csN <= 1'b0;
    {unitSelectHi, unitSelectLo} <= u;
    if (mux) begin
      lowAddrLines <= 5'h1f;
      hostBus <= {2'h0, a};
      addrStrobe <= 1'b1;
      tick(3);
      addrStrobe <= 1'b0;
    end else begin
      lowAddrLines <= a[4:0];
      addrStrobe <= a[5];
    end
    tick(3);
    if (!rd) hostBus <= d;
    if (timingStyleSel) begin
      strobePin <= act;
      dirPin <= rd;
    end else if (rd) strobePin <= 1'b0;
    else dirPin <= 1'b0;
    tick(4);
    @(negedge sys_clk);
    if (rd) chk(addrDataOe, 8'hff);
    if (rd) chk(addrDataOut, d);
    @(posedge sys_clk);
    strobePin <= !act;
    dirPin <= 1'b1;
    tick(3);
    @(negedge sys_clk);
    chk(addrDataOe, 8'h00);
    chk(regAddr, {2'h0, a});
    chk(regUnit, {6'h0, u});
    chk(8'(nRd - r0), 8'(rd));
    chk(8'(nWr - w0), 8'(!rd));
    if (!rd) chk(regWdata, d);
    @(posedge sys_clk);
    csN <= 1'b1;
    tick(2);
  endtask : par

  // Input bit is valid only around the chosen sample edge, so a wrong sample edge shows.
  // The line is read in the low phase, or late in the high phase; an undriven line reads as unknown.
  task automatic ser_byte(input logic [7:0] b, input bit fallIn, input bit late, output logic [7:0] q);
    for (int i = 0; i < 8; i++) begin
      dirPin <= b[i] ~^ fallIn;
      strobePin <= 1'b0;
      tick(2);
      dirPin <= b[i] ^ fallIn;
      tick(1);
      if (!late) begin
        @(negedge sys_clk);
        q[i] = addrDataOe[7] ? addrDataOut[7] : 1'bx;
      end
      @(posedge sys_clk);
      strobePin <= 1'b1;
      tick(3);
      if (late) begin
        @(negedge sys_clk);
        q[i] = addrDataOe[7] ? addrDataOut[7] : 1'bx;
      end
      @(posedge sys_clk);
    end
  endtask : ser_byte

  ////////////////////////////////////////////////////////////////////////////
  task par_modes;
    for (int i = 0; i < 4; i++) begin
      set_mode(i[0] ? qhp_pkg::PORT_NONMUX : qhp_pkg::PORT_MUX, i[1]);
      par(1'b0, i[1:0], 6'h21 + 6'(i * 7), 8'h5a + 8'(i * 17));
      par(1'b1, i[1:0], 6'h21 + 6'(i * 7), 8'h5a + 8'(i * 17));
    end
  endtask : par_modes

  task ignore_cases;
    int r0;
    set_mode(qhp_pkg::PORT_NONMUX, 1'b0);
    r0 = nRd;
    strobePin <= 1'b0;
    tick(5);
    @(negedge sys_clk);
    chk(addrDataOe, 8'h00);
    chk(8'(nRd - r0), 8'h00);
    @(posedge sys_clk);
    strobePin <= 1'b1;
    intPending <= 4'h8;
    tick(3);
    @(negedge sys_clk);
    chk({7'h0, intOe}, 8'h01);
    chk({7'h0, intOut}, 8'h00);
    @(posedge sys_clk);
    set_mode(qhp_pkg::PORT_TEST, 1'b0);
    csN <= 1'b0;
    strobePin <= 1'b0;
    tick(5);
    @(negedge sys_clk);
    chk(addrDataOe, 8'h00);
    chk({7'h0, intOe}, 8'h00);
    @(posedge sys_clk);
    intPending <= 4'h0;
  endtask : ignore_cases

  task serial_rw;
    set_mode(qhp_pkg::PORT_SERIAL, 1'b0);
    lowAddrLines <= 5'h00;
    {unitSelectHi, unitSelectLo} <= 2'h3;
    csN <= 1'b0;
    tick(3);
    ser_byte({2'b00, 5'h13, 1'b0}, 1'b0, 1'b0, r);
    ser_byte(8'ha6, 1'b0, 1'b0, r);
    @(negedge sys_clk);
    chk(regAddr, 6'h13);
    chk(regWdata, 8'ha6);
    @(posedge sys_clk);
    csN <= 1'b1;
    tick(3);
    csN <= 1'b0;
    tick(3);
    ser_byte({2'b00, 5'h13, 1'b1}, 1'b0, 1'b0, r);
    @(negedge sys_clk);
    chk(addrDataOe, 8'h80);
    @(posedge sys_clk);
    ser_byte(8'h00, 1'b0, 1'b0, r);
    chk(r, 8'ha6);
    @(posedge sys_clk);
    csN <= 1'b1;
    tick(2);
    @(negedge sys_clk);
    chk(addrDataOe, 8'h00);
  endtask : serial_rw

  // Falling-edge input and rising-edge output, with a burst write that wraps the address.
  task serial_edges;
    int w0;
    @(posedge sys_clk);
    set_mode(qhp_pkg::PORT_SERIAL, 1'b0);
    lowAddrLines <= 5'h03;
    {unitSelectHi, unitSelectLo} <= 2'h1;
    csN <= 1'b0;
    w0 = nWr;
    tick(3);
    ser_byte({1'b1, 1'b0, 5'h1f, 1'b0}, 1'b1, 1'b0, r);
    ser_byte(8'h3c, 1'b1, 1'b0, r);
    ser_byte(8'hc3, 1'b1, 1'b0, r);
    @(negedge sys_clk);
    chk(regAddr, 6'h00);
    chk(regWdata, 8'hc3);
    chk(8'(nWr - w0), 8'h02);
    @(posedge sys_clk);
    csN <= 1'b1;
    tick(3);
    csN <= 1'b0;
    tick(3);
    ser_byte({2'b00, 5'h00, 1'b1}, 1'b1, 1'b0, r);
    @(negedge sys_clk);
    chk(addrDataOe, 8'h80);
    @(posedge sys_clk);
    // Bit 0 leaves on the rising edge that closes the command, so each of the first seven late reads sees the next bit.
    ser_byte(8'h00, 1'b1, 1'b1, r);
    chk(r, 8'he1);
    @(posedge sys_clk);
    csN <= 1'b1;
    tick(2);
    @(negedge sys_clk);
    chk(addrDataOe, 8'h00);
  endtask : serial_edges

  initial begin
    {portKindSelHi, portKindSelLo} = qhp_pkg::PORT_NONMUX;
    {timingStyleSel, unitSelectHi, unitSelectLo, addrStrobe} = 4'h0;
    {csN, strobePin, dirPin} = 3'h7;
    lowAddrLines = 5'h00;
    hostBus = 8'h00;
    intPending = 4'h0;
    tick(6);
    reset_n <= 1'b1;
    tick(2);
    par_modes();
    ignore_cases();
    serial_rw();
    serial_edges();
    final_report();
  end

  initial begin
    tick(50000);
    errors++;
    final_report();
  end
endmodule : tb
